// ===== design/tocu_cmp_store.sv
// Purpose: 16-bit compare value store with double buffer and registered read
// Assumes: write strobes and update strobe are on the system clock
// Notes: read data always come from a flip-flop
module tocu_cmp_store
  import tocu_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  input wire logic buffered_i,
  input wire logic update_i,
  output logic [15:0] active_o,
  output logic [15:0] rdata_o
);

  logic [15:0] buf_ff;
  logic [15:0] act_ff;
  logic [15:0] rd_ff;

  // ****************************************************************
  // storage
  // ****************************************************************
  // only writes or the buffered transfer touch the value
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      buf_ff <= TOCU_CMP_RST;
      act_ff <= TOCU_CMP_RST;
      rd_ff <= TOCU_CMP_RST;
    end
    else if (ce_i)
    begin
      if (wr_i)
        buf_ff <= wdata_i;
      if (wr_i && !buffered_i)
        act_ff <= wdata_i;
      else if (buffered_i && update_i)
        act_ff <= buf_ff;
      rd_ff <= buffered_i ? buf_ff : act_ff;
    end
  end

  assign active_o = act_ff;
  assign rdata_o = rd_ff;

endmodule // tocu_cmp_store

// ===== design/tocu_pkg.sv
// Purpose: shared constants and types for the 16-bit timer output compare unit
// Assumes: one system clock, timer ticks arrive as a same-clock enable pulse
// Notes: mode codes follow the waveform mode select field encoding
package tocu_pkg;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int TOCU_CNT_W = 16;
  localparam int TOCU_NUM_CH = 2;
  localparam logic [15:0] TOCU_CMP_RST = 16'h0000;
  localparam logic [7:0] TOCU_TEMP_RST = 8'h00;
  localparam logic [15:0] TOCU_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOCU_CNT_BOTTOM = 16'h0000;

  // ****************************************************************
  // waveform mode codes
  // ****************************************************************
  localparam logic [3:0] TOCU_MODE_NORMAL = 4'h0;
  localparam logic [3:0] TOCU_MODE_CTC_CMP = 4'h4;
  localparam logic [3:0] TOCU_MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] TOCU_MODE_RSVD = 4'hD;
  // phase-and-frequency correct codes update buffer at bottom, all other pwm codes at top
  localparam logic [3:0] TOCU_MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] TOCU_MODE_PFC_CMP = 4'h9;

  // ****************************************************************
  // output action encodings
  // ****************************************************************
  localparam logic [1:0] TOCU_ACT_NONE = 2'h0;
  localparam logic [1:0] TOCU_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TOCU_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TOCU_ACT_SET = 2'h3;

  // ****************************************************************
  // per-channel and shared unit state
  // ****************************************************************
  typedef struct packed {
    logic [15:0] cmp_buf;
    logic [15:0] cmp_act;
    logic match_pend;
    logic flag;
    logic out_bit;
  } tocu_ch_t;

  typedef struct packed {
    tocu_ch_t [1:0] ch;
    logic [7:0] temp;
    logic block_pend;
  } tocu_state_t;

  // cpu write strobes for one channel: compare value bytes, flag clear and force
  typedef struct packed {
    logic wr_high;
    logic wr_low;
    logic flag_clr;
    logic force_strobe;
  } tocu_cpu_wr_t;

endpackage : tocu_pkg

// ===== design/tocu_unit.sv
// Purpose: two output compare channels of a 16-bit timer
// Assumes: counter value, top and bottom strobes come from the counter block
// Notes: cpu byte writes arrive as one-cycle strobes, no register bus

module tocu_unit
  import tocu_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic TIMER_TICK_I,
  input wire logic [15:0] COUNT_VALUE_I,
  input wire logic COUNT_TOP_I,
  input wire logic COUNT_BOTTOM_I,
  input wire logic COUNT_WRITE_I,
  input wire logic [15:0] CAPTURE_VALUE_REG_I,
  input wire logic [3:0] WAVEFORM_MODE_SEL_I,
  input wire logic [7:0] CPU_WDATA_I,
  input wire tocu_cpu_wr_t [1:0] CPU_WR_I,
  input wire logic [1:0] COMPARE_IRQ_ENABLE_I,
  input wire logic [1:0] IRQ_ACK_I,
  input wire logic [3:0] OUTPUT_ACTION_SEL_I,
  input wire logic [1:0] PORT_OUT_I,
  input wire logic [1:0] COMPARE_PIN_DIRECTION_BIT_I,
  output logic [15:0] COMPARE_VALUE_A_O,
  output logic [15:0] COMPARE_VALUE_B_O,
  output logic [1:0] COMPARE_MATCH_FLAG_O,
  output logic [1:0] FORCE_COMPARE_STROBE_RD_O,
  output logic [1:0] IRQ_O,
  output logic [1:0] COMPARE_OUTPUT_BIT_O,
  output logic [1:0] PIN_OUT_O,
  output logic [1:0] PIN_OE_N_O,
  output logic [15:0] COUNT_TOP_VALUE_O,
  output logic COUNT_CLEAR_O
);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // pwm modes are all codes except normal and both ctc codes
  function automatic logic is_pwm(input logic [3:0] mode);
    is_pwm = !(mode == TOCU_MODE_NORMAL || mode == TOCU_MODE_CTC_CMP ||
               mode == TOCU_MODE_CTC_CAP);
  endfunction

  // next output bit for one action code at a match
  function automatic logic act_out(input logic [1:0] act, input logic cur,
                                   input logic pwm, input logic at_top);
    logic res;
    res = cur;
    unique case (act)
      TOCU_ACT_NONE: res = cur;
      TOCU_ACT_TOGGLE: res = pwm ? cur : ~cur;
      TOCU_ACT_CLEAR: res = (pwm && at_top) ? 1'b1 : 1'b0;
      TOCU_ACT_SET: res = (pwm && at_top) ? 1'b0 : 1'b1;
    endcase
    act_out = res;
  endfunction

  // ****************************************************************
  // state and compare stores
  // ****************************************************************
  tocu_state_t state_ff;
  tocu_state_t nxt_state;
  logic [1:0][15:0] cmp_active;
  logic [1:0][15:0] cmp_rdata;
  logic pwm_mode;
  logic buf_update;
  logic [15:0] wr_value;

  assign pwm_mode = is_pwm(WAVEFORM_MODE_SEL_I);
  // phase-and-frequency correct modes update at bottom, others at top
  assign buf_update = TIMER_TICK_I &&
    ((WAVEFORM_MODE_SEL_I == TOCU_MODE_PFC_CAP ||
      WAVEFORM_MODE_SEL_I == TOCU_MODE_PFC_CMP) ? COUNT_BOTTOM_I : COUNT_TOP_I);
  // both bytes land together from the holding byte and the low write
  assign wr_value = {state_ff.temp, CPU_WDATA_I};

  genvar gi;
  generate
    for (gi = 0; gi < TOCU_NUM_CH; gi++)
    begin : g_store
      tocu_cmp_store u_store (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .wr_i(CPU_WR_I[gi].wr_low),
        .wdata_i(wr_value),
        .buffered_i(pwm_mode),
        .update_i(buf_update),
        .active_o(cmp_active[gi]),
        .rdata_o(cmp_rdata[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb
  begin
    logic eq;
    logic at_top;
    logic fire;
    logic [1:0] act;
    eq = 1'b0;
    at_top = 1'b0;
    fire = 1'b0;
    act = TOCU_ACT_NONE;
    nxt_state = state_ff;
    // holding byte shared by both channels
    for (int c = 0; c < TOCU_NUM_CH; c++)
      if (CPU_WR_I[c].wr_high)
        nxt_state.temp = CPU_WDATA_I;
    // a counter write blocks matches on the next tick, even if stopped
    if (COUNT_WRITE_I)
      nxt_state.block_pend = 1'b1;
    else if (TIMER_TICK_I)
      nxt_state.block_pend = 1'b0;
    for (int c = 0; c < TOCU_NUM_CH; c++)
    begin
      eq = (COUNT_VALUE_I == cmp_active[c]);
      at_top = COUNT_TOP_I;
      act = OUTPUT_ACTION_SEL_I[2*c +: 2];
      fire = 1'b0;
      if (TIMER_TICK_I)
      begin
        // match seen now is taken on the following tick
        fire = state_ff.ch[c].match_pend;
        nxt_state.ch[c].match_pend = eq && !state_ff.block_pend &&
                                     !COUNT_WRITE_I;
      end
      // service acknowledge or software write-one clears; a set wins
      if (IRQ_ACK_I[c] || CPU_WR_I[c].flag_clr)
        nxt_state.ch[c].flag = 1'b0;
      if (fire)
        nxt_state.ch[c].flag = 1'b1;
      // output bit follows the action; mode change alone never touches it
      if (fire)
        nxt_state.ch[c].out_bit = act_out(act, state_ff.ch[c].out_bit,
                                          pwm_mode, at_top);
      else if (CPU_WR_I[c].force_strobe && !pwm_mode)
        nxt_state.ch[c].out_bit = act_out(act, state_ff.ch[c].out_bit,
                                          1'b0, 1'b0);
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      state_ff <= '0;
    else if (CE_I)
      state_ff <= nxt_state;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // counter top and clear requests; normal mode never clears
  always_comb
  begin
    COUNT_TOP_VALUE_O = TOCU_CNT_MAX;
    COUNT_CLEAR_O = 1'b0;
    if (WAVEFORM_MODE_SEL_I == TOCU_MODE_CTC_CMP)
    begin
      COUNT_TOP_VALUE_O = cmp_active[0];
      COUNT_CLEAR_O = (COUNT_VALUE_I == cmp_active[0]) && !state_ff.block_pend;
    end
    else if (WAVEFORM_MODE_SEL_I == TOCU_MODE_CTC_CAP)
    begin
      COUNT_TOP_VALUE_O = CAPTURE_VALUE_REG_I;
      COUNT_CLEAR_O = (COUNT_VALUE_I == CAPTURE_VALUE_REG_I) && !state_ff.block_pend;
    end
    else if (pwm_mode && WAVEFORM_MODE_SEL_I[0] && WAVEFORM_MODE_SEL_I[1])
      COUNT_TOP_VALUE_O = cmp_active[0];
  end

  assign COMPARE_VALUE_A_O = cmp_rdata[0];
  assign COMPARE_VALUE_B_O = cmp_rdata[1];
  assign FORCE_COMPARE_STROBE_RD_O = 2'b00;

  // pin mux: output bit overrides port data unless the action is none, direction untouched
  always_comb
  begin
    for (int c = 0; c < TOCU_NUM_CH; c++)
    begin
      COMPARE_MATCH_FLAG_O[c] = state_ff.ch[c].flag;
      IRQ_O[c] = state_ff.ch[c].flag && COMPARE_IRQ_ENABLE_I[c];
      COMPARE_OUTPUT_BIT_O[c] = state_ff.ch[c].out_bit;
      PIN_OUT_O[c] = (OUTPUT_ACTION_SEL_I[2*c +: 2] != TOCU_ACT_NONE) ?
                     state_ff.ch[c].out_bit : PORT_OUT_I[c];
      PIN_OE_N_O[c] = !COMPARE_PIN_DIRECTION_BIT_I[c];
    end
  end

endmodule // tocu_unit

// ===== sim/tocu_cpu_model.sv
// Purpose: cpu side of the compare unit, byte writes and strobes
// Assumes: one system clock
// Notes: idle data bus shows the inverse of the last byte
module tocu_cpu_model
  import tocu_pkg::*;
(
  input wire logic clk_i,
  output logic [7:0] wdata_o,
  output tocu_cpu_wr_t [1:0] wr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // bus tasks
  // ****
  initial wdata_o = 8'h00;
  initial wr_o = '0;
  // high byte first so the holding byte is loaded before the low byte
  task automatic wr16(input int ch, input logic [15:0] v);
    @(posedge clk_i);
    wdata_o <= v[15:8];
    wr_o[ch].wr_high <= 1'b1;
    @(posedge clk_i);
    wr_o[ch].wr_high <= 1'b0;
    wr_o[ch].wr_low <= 1'b1;
    wdata_o <= v[7:0];
    @(posedge clk_i);
    wr_o[ch] <= '0;
    wdata_o <= ~v[7:0]; // stale byte must not look valid
  endtask
  // one-cycle strobe such as flag clear or force
  task automatic strb(input int ch, input tocu_cpu_wr_t s);
    @(posedge clk_i);
    wr_o[ch] <= s;
    @(posedge clk_i);
    wr_o[ch] <= '0;
  endtask
endmodule // tocu_cpu_model

// ===== sim/tocu_unit_asserts.sv
// Purpose: port checker for the compare unit
// Assumes: one clock, async active-low reset
// Notes: bound from the bench top, channel A watched in detail
module tocu_unit_asserts
  import tocu_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic TIMER_TICK_I,
  input wire logic [15:0] CAPTURE_VALUE_REG_I,
  input wire logic [3:0] WAVEFORM_MODE_SEL_I,
  input wire logic [7:0] CPU_WDATA_I,
  input wire tocu_cpu_wr_t [1:0] CPU_WR_I,
  input wire logic [1:0] COMPARE_IRQ_ENABLE_I,
  input wire logic [1:0] IRQ_ACK_I,
  input wire logic [3:0] OUTPUT_ACTION_SEL_I,
  input wire logic [1:0] COMPARE_PIN_DIRECTION_BIT_I,
  input wire logic [15:0] COMPARE_VALUE_A_O,
  input wire logic [1:0] COMPARE_MATCH_FLAG_O,
  input wire logic [1:0] IRQ_O,
  input wire logic [1:0] COMPARE_OUTPUT_BIT_O,
  input wire logic [1:0] PIN_OUT_O,
  input wire logic [1:0] PIN_OE_N_O,
  input wire logic [15:0] COUNT_TOP_VALUE_O
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // high then low byte write to channel A
  sequence s_pair;
    CE_I && CPU_WR_I[0].wr_high ##1 CE_I && CPU_WR_I[0].wr_low;
  endsequence
  AST_PAIR: assert property (s_pair ##0 WAVEFORM_MODE_SEL_I == TOCU_MODE_NORMAL |=>
    ##1 COMPARE_VALUE_A_O == {$past(CPU_WDATA_I, 3), $past(CPU_WDATA_I, 2)})
    else $error("compare value not built from the two bytes");
  AST_IRQ: assert property (IRQ_O == (COMPARE_MATCH_FLAG_O & COMPARE_IRQ_ENABLE_I))
    else $error("irq not flag and enable");
  AST_ACK: assert property (CE_I && IRQ_ACK_I[0] && !TIMER_TICK_I |=>
    !COMPARE_MATCH_FLAG_O[0]) else $error("ack left flag set");
  AST_CLR: assert property (CE_I && CPU_WR_I[0].flag_clr && !TIMER_TICK_I |=>
    !COMPARE_MATCH_FLAG_O[0]) else $error("write one left flag set");
  AST_RISE: assert property ($rose(COMPARE_MATCH_FLAG_O[0]) |-> $past(TIMER_TICK_I))
    else $error("flag set outside a timer tick");
  AST_NOACT: assert property (OUTPUT_ACTION_SEL_I[1:0] == TOCU_ACT_NONE |=>
    $stable(COMPARE_OUTPUT_BIT_O[0])) else $error("output bit moved with no action");
  AST_PIN: assert property (OUTPUT_ACTION_SEL_I[1:0] != TOCU_ACT_NONE |->
    PIN_OUT_O[0] == COMPARE_OUTPUT_BIT_O[0]) else $error("pin not overridden");
  AST_OE: assert property (PIN_OE_N_O == ~COMPARE_PIN_DIRECTION_BIT_I)
    else $error("pin enable not from direction");
  AST_TOP: assert property (WAVEFORM_MODE_SEL_I == TOCU_MODE_CTC_CAP |->
    COUNT_TOP_VALUE_O == CAPTURE_VALUE_REG_I) else $error("top not capture value");
endmodule // tocu_unit_asserts

// ===== sim/tocu_unit_bench.sv
// Purpose: self-checking bench for the compare unit
// Assumes: counter is played by the bench as plain levels
// Notes: one task per scenario, cpu model drives byte writes
module tocu_unit_bench
  import tocu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals and design
  // ****
  logic clk = 1'b0, rst_n = 1'b0, tk = 1'b0, cwr = 1'b0, top = 1'b0, clr;
  logic [1:0] frd;
  logic [15:0] vb;
  logic [15:0] cnt = 16'h0000;
  logic [3:0] mode = 4'h0, act = 4'h0;
  logic [1:0] en = 2'h0, ack = 2'h0, dir = 2'h0;
  logic [7:0] wd;
  tocu_cpu_wr_t [1:0] wr;
  logic [15:0] va, topv;
  logic [1:0] flag, irq, ob, pout, poe;
  int err_total = 0;
  int compares = 0;
  always #5 clk = ~clk;
  tocu_cpu_model cpu (.clk_i(clk), .wdata_o(wd), .wr_o(wr));
  tocu_unit DUT (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .TIMER_TICK_I(tk),
    .COUNT_VALUE_I(cnt), .COUNT_TOP_I(top), .COUNT_BOTTOM_I(1'b0), .COUNT_WRITE_I(cwr),
    .CAPTURE_VALUE_REG_I(16'h0ABC), .WAVEFORM_MODE_SEL_I(mode), .CPU_WDATA_I(wd),
    .CPU_WR_I(wr), .COMPARE_IRQ_ENABLE_I(en), .IRQ_ACK_I(ack), .OUTPUT_ACTION_SEL_I(act),
    .PORT_OUT_I(2'h0), .COMPARE_PIN_DIRECTION_BIT_I(dir), .COMPARE_VALUE_A_O(va),
    .COMPARE_VALUE_B_O(vb), .COMPARE_MATCH_FLAG_O(flag), .FORCE_COMPARE_STROBE_RD_O(frd),
    .IRQ_O(irq), .COMPARE_OUTPUT_BIT_O(ob), .PIN_OUT_O(pout), .PIN_OE_N_O(poe),
    .COUNT_TOP_VALUE_O(topv), .COUNT_CLEAR_O(clr)
  );
  // ****
  // helpers
  // ****
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    tk <= 1'b1;
    @(posedge clk);
    tk <= 1'b0;
  endtask
  // equal count on one tick, moved on by the next, which lands the flag
  task automatic hit();
    cnt <= 16'h0012;
    tick();
    cnt <= 16'h0013;
    tick();
    @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic s_write();
    cpu.wr16(0, 16'h0012);
    repeat (2) @(posedge clk);
    #1;
    chk(16'h0012, va);
  endtask
  task automatic s_match();
    en <= 2'h1;
    act <= 4'h1;
    dir <= 2'h1;
    hit();
    chk(16'h0003, 16'({irq[0], flag[0]}));
    chk(16'h0006, 16'({ob[0], pout[0], poe[0]}));
    cpu.strb(0, 4'h2);
    #1;
    chk(16'h0000, 16'(flag));
  endtask
  // counter write just before the equal tick must swallow the match
  task automatic s_block();
    @(posedge clk);
    cwr <= 1'b1;
    @(posedge clk);
    cwr <= 1'b0;
    hit();
    chk(16'h0002, 16'({ob[0], flag[0]}));
  endtask
  task automatic s_ack_force();
    act <= 4'hE;
    hit();
    chk(16'h0001, 16'({ob[0], flag[0]}));
    @(posedge clk);
    ack <= 2'h1;
    @(posedge clk);
    ack <= 2'h0;
    #1;
    chk(16'h0000, 16'(flag));
    cpu.strb(1, 4'h1);
    @(posedge clk);
    #1;
    chk(16'h0008, 16'({ob, flag}));
    chk(16'h0000, 16'(frd));
    mode <= 4'hC;
    cnt <= 16'h0ABC;
    @(posedge clk);
    #1;
    chk(16'h0ABC, topv);
    chk(16'h0001, 16'(clr));
    chk(16'h0002, 16'(ob));
  endtask
  // pwm mode with top from channel A: writes stay in the buffer until top
  task automatic s_pwm();
    mode <= 4'hB;
    cpu.wr16(0, 16'h0077);
    cpu.wr16(1, 16'h0055);
    @(posedge clk);
    #1;
    chk(16'h0077, va);
    chk(16'h0055, vb);
    chk(16'h0012, topv);
    @(posedge clk);
    top <= 1'b1;
    tk <= 1'b1;
    @(posedge clk);
    top <= 1'b0;
    tk <= 1'b0;
    #1;
    chk(16'h0077, topv);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(16'h0000, 16'({flag, ob}));
    s_write();
    s_match();
    s_block();
    s_ack_force();
    s_pwm();
    print_verdict();
  end
  // hang guard, far beyond the roughly 56 cycles of the run
  initial
  begin
    #100us;
    err_total++;
    print_verdict();
  end
endmodule // tocu_unit_bench
bind tocu_unit tocu_unit_asserts chk_a (.*);
